// File: include/vcfg_pkg.sv
// Package of constants and types for the volatile configuration block
package vcfg_pkg;
	localparam logic [7:0] addr_mode_select  = 8'h00;
	localparam logic [7:0] addr_dummy        = 8'h01;
	localparam logic [7:0] addr_lock_bits    = 8'h02;
	localparam logic [7:0] addr_wrap         = 8'h06;
	localparam logic [7:0] addr_wrap_alt     = 8'h07;
	localparam logic [7:0] dummy_default_lo  = 8'h00;
	localparam logic [7:0] dummy_max         = 8'h1e;
	localparam logic [7:0] dummy_default_hi  = 8'h1f;
	localparam logic [7:0] mode_ext_strobe   = 8'hff;
	localparam logic [7:0] mode_ext_plain    = 8'hdf;
	localparam logic [7:0] mode_odr_strobe   = 8'he7;
	localparam logic [7:0] mode_odr_plain    = 8'hc7;
	localparam logic [7:0] wrap_continuous   = 8'hff;
	localparam logic [7:0] wrap_64           = 8'hfe;
	localparam logic [7:0] wrap_32           = 8'hfd;
	localparam logic [7:0] wrap_16           = 8'hfc;
	localparam logic [7:0] lock_set_only     = 8'h91;
	localparam int         complement_bit    = 5;
	localparam logic [7:0] lock_reset        = 8'h10;
	localparam logic [7:0] id_ext_length     = 8'h02;
	localparam logic [7:0] id_rev_64k        = 8'h00;
	localparam logic [7:0] id_rev_128k       = 8'h01;
	localparam logic [7:0] id_cfg_ext        = 8'h00;
	localparam logic [7:0] id_cfg_odr        = 8'h04;
	localparam logic [7:0] cmd_id_a          = 8'h9f;
	localparam logic [7:0] cmd_id_b          = 8'h9e;
	localparam int         id_length         = 6;

	typedef struct packed {
		logic [7:0] mode_select;
		logic [7:0] dummy;
		logic [7:0] wrap;
		logic [7:0] lock;
	} config_type;

	typedef struct packed {
		logic       octal_double_rate_mode;
		logic       read_data_strobe;
		logic       use_default_dummy;
		logic [4:0] dummy_cycles;
		logic [1:0] wrap_sel;
	} decoded_type;
endpackage

// File: hdl/vcfg_link_sync.sv
// Two-flop synchroniser with edge detection for the host serial link pins
module vcfg_link_sync #(
	parameter int width = 3
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [width-1:0] pin_in,
	output logic      [width-1:0] level,
	output logic      [width-1:0] rise,
	output logic      [width-1:0] fall
);
	logic [width-1:0] stage_a;
	logic [width-1:0] stage_b;
	logic [width-1:0] stage_c;

	if (width < 1)
	begin : width_check
		$error("width must be positive");
	end

	// Flops follow the pins through reset, so no false edge appears at release
	always_ff @(posedge mclk)
	begin
		stage_a <= pin_in;
		stage_b <= stage_a;
		stage_c <= stage_b;
	end

	assign level = stage_b;
	assign rise  = stage_b & ~stage_c & {width{!rst}};
	assign fall  = ~stage_b & stage_c & {width{!rst}};
endmodule // vcfg_link_sync

// File: hdl/flash_volatile_config_wrap_id.sv
// Volatile configuration, wrap addressing and ID byte stream of an octal flash
module flash_volatile_config_wrap_id #(
	parameter logic [7:0] maker_code    = 8'h5a, // Arbitrary value
	parameter logic [7:0] type_code     = 8'h11, // Arbitrary value
	parameter logic [7:0] capacity_code = 8'h22, // Arbitrary value
	parameter bit         block_128k    = 1'b0,
	parameter int         addr_width    = 32
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  power_up,
	input  wire logic [7:0]            stored_mode_default,
	input  wire logic [7:0]            stored_dummy_default,
	input  wire logic [7:0]            stored_wrap_default,
	input  wire logic                  volatile_config_write,
	input  wire logic [7:0]            write_addr,
	input  wire logic [7:0]            write_data,
	input  wire logic                  sclk_pin,
	input  wire logic                  cs_n_pin,
	input  wire logic [7:0]            command,
	input  wire logic                  command_valid,
	input  wire logic                  burst_load,
	input  wire logic [addr_width-1:0] burst_start,
	output logic [7:0]                 interface_mode_select,
	output logic [7:0]                 dummy_cycle_count,
	output logic [7:0]                 burst_wrap_size,
	output logic [7:0]                 lock_bits,
	output logic                       complement_protect,
	output logic                       octal_double_rate_mode,
	output logic                       read_data_strobe,
	output logic                       use_default_dummy,
	output logic [4:0]                 dummy_cycles,
	output logic [addr_width-1:0]      burst_addr,
	output logic [7:0]                 id_byte,
	output logic                       id_valid
);
	vcfg_pkg::decoded_type next_decoded;
	logic                  sclk_rise;
	logic                  cs_n_level;
	logic                  write_ok;
	logic                  id_active;
	logic [2:0]            id_index;
	logic [7:0]            id_table [vcfg_pkg::id_length];
	logic [addr_width-1:0] wrap_mask;
	logic [addr_width-1:0] next_addr;
	logic                  unused_sclk_level;
	logic                  unused_cs_rise;

	if (addr_width < 7)
	begin : addr_width_check
		$error("addr_width must cover a 64-byte block");
	end

	vcfg_link_sync #(
		.width (2)
	) link_sync (
		.mclk   (mclk),
		.rst    (rst),
		.pin_in ({cs_n_pin, sclk_pin}),
		.level  ({cs_n_level, unused_sclk_level}),
		.rise   ({unused_cs_rise, sclk_rise}),
		.fall   ()
	);

	// Set-only bits may never be cleared by a write, only by reset or power-up
	assign write_ok = ((write_data & vcfg_pkg::lock_set_only) == vcfg_pkg::lock_set_only);

	// Configuration registers
	always_ff @(posedge mclk)
	begin
		if (rst || power_up)
		begin
			interface_mode_select <= stored_mode_default;
			dummy_cycle_count     <= stored_dummy_default;
			burst_wrap_size       <= stored_wrap_default;
		end
		else if (volatile_config_write)
		begin
			if (write_addr == vcfg_pkg::addr_mode_select)
			begin
				if (write_data == vcfg_pkg::mode_ext_strobe || write_data == vcfg_pkg::mode_ext_plain
					|| write_data == vcfg_pkg::mode_odr_strobe
					|| write_data == vcfg_pkg::mode_odr_plain)
					interface_mode_select <= write_data;
			end
			else if (write_addr == vcfg_pkg::addr_dummy)
			begin
				if (write_data <= vcfg_pkg::dummy_default_hi)
					dummy_cycle_count <= write_data;
			end
			else if (write_addr == vcfg_pkg::addr_wrap || write_addr == vcfg_pkg::addr_wrap_alt)
			begin
				if (write_data >= vcfg_pkg::wrap_16)
					burst_wrap_size <= write_data;
			end
		end
	end

	// Lock byte, complement bit survives resets other than power-up
	always_ff @(posedge mclk)
	begin
		if (power_up)
			lock_bits <= vcfg_pkg::lock_reset;
		else if (rst)
			lock_bits <= (vcfg_pkg::lock_reset & ~(8'h01 << vcfg_pkg::complement_bit))
				| (lock_bits & (8'h01 << vcfg_pkg::complement_bit));
		else if (volatile_config_write && write_addr == vcfg_pkg::addr_lock_bits && write_ok)
			lock_bits <= write_data;
	end

	// Decode of the live settings
	always_comb
	begin
		next_decoded.octal_double_rate_mode = (interface_mode_select == vcfg_pkg::mode_odr_strobe)
			|| (interface_mode_select == vcfg_pkg::mode_odr_plain);
		next_decoded.read_data_strobe = (interface_mode_select == vcfg_pkg::mode_ext_strobe)
			|| (interface_mode_select == vcfg_pkg::mode_odr_strobe);
		next_decoded.use_default_dummy = (dummy_cycle_count == vcfg_pkg::dummy_default_lo)
			|| (dummy_cycle_count == vcfg_pkg::dummy_default_hi);
		next_decoded.dummy_cycles = next_decoded.use_default_dummy ? 5'h00
			: dummy_cycle_count[4:0];
		if (burst_wrap_size == vcfg_pkg::wrap_64)
			next_decoded.wrap_sel = 2'h3;
		else if (burst_wrap_size == vcfg_pkg::wrap_32)
			next_decoded.wrap_sel = 2'h2;
		else if (burst_wrap_size == vcfg_pkg::wrap_16)
			next_decoded.wrap_sel = 2'h1;
		else
			next_decoded.wrap_sel = 2'h0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			octal_double_rate_mode <= 1'b0;
			read_data_strobe       <= 1'b0;
			use_default_dummy      <= 1'b1;
			dummy_cycles           <= 5'h00;
		end
		else
		begin
			octal_double_rate_mode <= next_decoded.octal_double_rate_mode;
			read_data_strobe       <= next_decoded.read_data_strobe;
			use_default_dummy      <= next_decoded.use_default_dummy;
			dummy_cycles           <= next_decoded.dummy_cycles;
		end
	end

	assign complement_protect = lock_bits[vcfg_pkg::complement_bit];

	// Wrap address generator, one step per rising link clock edge
	always_comb
	begin
		wrap_mask = '0;
		case (next_decoded.wrap_sel)
			2'h1: wrap_mask = addr_width'(8'h0f);
			2'h2: wrap_mask = addr_width'(8'h1f);
			2'h3: wrap_mask = addr_width'(8'h3f);
			default: wrap_mask = '0;
		endcase
		if (next_decoded.wrap_sel == 2'h0)
			next_addr = burst_addr + addr_width'(1);
		else
			next_addr = (burst_addr & ~wrap_mask) | ((burst_addr + addr_width'(1)) & wrap_mask);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			burst_addr <= '0;
		else if (burst_load)
			burst_addr <= burst_start;
		else if (sclk_rise && !cs_n_level && !id_active)
			burst_addr <= next_addr;
	end

	// Identification byte stream
	always_comb
	begin
		id_table[0] = maker_code;
		id_table[1] = type_code;
		id_table[2] = capacity_code;
		id_table[3] = vcfg_pkg::id_ext_length;
		id_table[4] = block_128k ? vcfg_pkg::id_rev_128k : vcfg_pkg::id_rev_64k;
		id_table[5] = (stored_mode_default == vcfg_pkg::mode_odr_strobe)
			? vcfg_pkg::id_cfg_odr : vcfg_pkg::id_cfg_ext;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || cs_n_level)
		begin
			id_active <= 1'b0;
			id_index  <= 3'h0;
			id_byte   <= 8'h00;
			id_valid  <= 1'b0;
		end
		else if (command_valid && (command == vcfg_pkg::cmd_id_a || command == vcfg_pkg::cmd_id_b))
		begin
			id_active <= 1'b1;
			id_index  <= 3'h1;
			id_byte   <= id_table[0];
			id_valid  <= 1'b1;
		end
		else if (id_active && sclk_rise)
		begin
			id_byte  <= id_table[id_index];
			id_valid <= 1'b1;
			if (id_index == 3'(vcfg_pkg::id_length - 1))
				id_active <= 1'b0;
			id_index <= id_index + 3'h1;
		end
		else
			id_valid <= 1'b0;
	end
endmodule // flash_volatile_config_wrap_id

// File: test/vcfg_monitor.sv
// Checker of register writes, reset loading and mode decode
module vcfg_monitor (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       power_up,
	input wire logic       volatile_config_write,
	input wire logic [7:0] write_addr,
	input wire logic [7:0] write_data,
	input wire logic [7:0] stored_wrap_default,
	input wire logic [7:0] interface_mode_select,
	input wire logic [7:0] dummy_cycle_count,
	input wire logic [7:0] burst_wrap_size,
	input wire logic [7:0] lock_bits,
	input wire logic       complement_protect,
	input wire logic       octal_double_rate_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] age;
	always_ff @(posedge mclk)
	begin
		if (rst || power_up)
			age <= 2'd0;
		else if (age != 2'd3)
			age <= age + 2'd1;
	end
	sequence wr(logic [7:0] a);
		volatile_config_write && !power_up && write_addr == a;
	endsequence
	dummy_take_a: assert property (@(posedge mclk) disable iff (rst || power_up)
		wr(8'h01) ##0 write_data <= 8'h1f |=> dummy_cycle_count == $past(write_data))
		else $error("dummy write lost");
	dummy_keep_a: assert property (@(posedge mclk) disable iff (rst || power_up)
		wr(8'h01) ##0 write_data > 8'h1f |=> $stable(dummy_cycle_count))
		else $error("reserved dummy taken");
	mode_keep_a: assert property (@(posedge mclk) disable iff (rst || power_up)
		wr(8'h00) ##0 !(write_data inside {8'hff, 8'hdf, 8'he7, 8'hc7})
		|=> $stable(interface_mode_select)) else $error("reserved mode taken");
	wrap_take_a: assert property (@(posedge mclk) disable iff (rst || power_up)
		volatile_config_write && write_addr[7:1] == 7'h03 && write_data >= 8'hfc
		|=> burst_wrap_size == $past(write_data)) else $error("wrap write lost");
	lock_keep_a: assert property (@(posedge mclk) disable iff (rst || power_up)
		wr(8'h02) ##0 (~write_data & 8'h91) != 8'h00 |=> $stable(lock_bits))
		else $error("lock clear taken");
	wrap_load_a: assert property (@(posedge mclk)
		rst |=> burst_wrap_size == $past(stored_wrap_default)) else $error("wrap not loaded");
	cmp_keep_a: assert property (@(posedge mclk)
		rst && !power_up |=> complement_protect == $past(complement_protect))
		else $error("complement bit lost");
	mode_decode_a: assert property (@(posedge mclk) disable iff (rst || power_up)
		age == 2'd3 |-> octal_double_rate_mode == ($past(interface_mode_select) inside
		{8'he7, 8'hc7})) else $error("octal decode wrong");
endmodule // vcfg_monitor

bind flash_volatile_config_wrap_id vcfg_monitor mon_u (.mclk(mclk), .rst(rst),
	.power_up(power_up), .volatile_config_write(volatile_config_write),
	.write_addr(write_addr), .write_data(write_data),
	.stored_wrap_default(stored_wrap_default), .interface_mode_select(interface_mode_select),
	.dummy_cycle_count(dummy_cycle_count), .burst_wrap_size(burst_wrap_size),
	.lock_bits(lock_bits), .complement_protect(complement_protect),
	.octal_double_rate_mode(octal_double_rate_mode));

// File: test/host_link_model.sv
// Host controller model: chip select and serial clock frames
module host_link_model (
	output logic sclk_pin,
	output logic cs_n_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		sclk_pin = 1'b0;
		cs_n_pin = 1'b1;
	end
	// Clock stands low outside frames; slow rate suits any dummy count
	task automatic frame(input int n);
		cs_n_pin = 1'b0;
		#160;
		repeat (n)
		begin
			sclk_pin = 1'b1;
			#80;
			sclk_pin = 1'b0;
			#80;
		end
		cs_n_pin = 1'b1;
		#160;
	endtask
endmodule // host_link_model

// File: test/flash_volatile_config_wrap_id_tb.sv
// Testbench of the volatile configuration block
module flash_volatile_config_wrap_id_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 0, rst = 1, power_up = 1, wr = 0, cv = 0, load = 0;
	logic [7:0]  wa = 0, wd = 0, cmd = 0, smode = 8'hff, sdum = 0, swrap = 8'hff;
	logic [7:0]  mo, du, wp, lk, idb, em, ed, ew, el = 8'h10;
	logic [4:0]  dc;
	logic [31:0] bs = 0, ba;
	logic        cmp, odr, stb, udd, idv, sclk, cs_n;
	logic [7:0]  modes [4] = '{8'hff, 8'hdf, 8'he7, 8'hc7};
	logic [15:0] vec [16] = '{16'h00ff, 16'h00df, 16'h00e7, 16'h00c7, 16'h0000, 16'h0100,
		16'h0101, 16'h011e, 16'h011f, 16'h0120, 16'h06fc, 16'h07fd, 16'h06fb, 16'h02b1,
		16'h0221, 16'h05aa};
	logic [7:0]  idq [$];
	int          seed = 32'h88fe, fail_count = 0, checks = 0, cyc = 0;
	always #10 mclk = ~mclk;
	flash_volatile_config_wrap_id #(.maker_code(8'h3c), .type_code(8'h4d),
		.capacity_code(8'h6e)) dut_u (.mclk(mclk), .rst(rst),
		.power_up(power_up), .stored_mode_default(smode), .stored_dummy_default(sdum),
		.stored_wrap_default(swrap), .volatile_config_write(wr), .write_addr(wa),
		.write_data(wd), .sclk_pin(sclk), .cs_n_pin(cs_n), .command(cmd), .command_valid(cv),
		.burst_load(load), .burst_start(bs), .interface_mode_select(mo),
		.dummy_cycle_count(du), .burst_wrap_size(wp), .lock_bits(lk),
		.complement_protect(cmp), .octal_double_rate_mode(odr), .read_data_strobe(stb),
		.use_default_dummy(udd), .dummy_cycles(dc), .burst_addr(ba), .id_byte(idb),
		.id_valid(idv));
	host_link_model link_u (.sclk_pin(sclk), .cs_n_pin(cs_n));
	always @(posedge mclk)
	begin
		if (idv === 1'b1)
			idq.push_back(idb);
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task check_regs;
		chk("mode", em, mo);
		chk("dummy", ed, du);
		chk("wrap", ew, wp);
		chk("lock", el, lk);
		chk("cmp", el[5], cmp);
		chk("odr", em inside {8'he7, 8'hc7}, odr);
		chk("strobe", em inside {8'hff, 8'he7}, stb);
		chk("deflt", ed inside {8'h00, 8'h1f}, udd);
		chk("cycles", (ed inside {8'h00, 8'h1f}) ? 5'd0 : ed[4:0], dc);
	endtask
	task do_reset(input logic pu);
		@(posedge mclk) #2;
		smode = modes[$random(seed) & 3];
		sdum = 8'($random(seed)) & 8'h1f;
		swrap = 8'hfc | (8'($random(seed)) & 8'h03);
		rst = 1;
		power_up = pu;
		repeat (20) @(posedge mclk);
		#2 rst = 0;
		power_up = 0;
		em = smode;
		ed = sdum;
		ew = swrap;
		el = pu ? 8'h10 : (el & 8'h20) | 8'h10;
		repeat (3) @(posedge mclk);
		#2 check_regs();
		$display("reset done");
	endtask
	task wr8(input logic [7:0] a, input logic [7:0] d);
		wr = 1;
		wa = a;
		wd = d;
		@(posedge mclk) #2 wr = 0;
		if (a == 8'h00 && d inside {8'hff, 8'hdf, 8'he7, 8'hc7}) em = d;
		if (a == 8'h01 && d <= 8'h1f) ed = d;
		if (a[7:1] == 7'h03 && d >= 8'hfc) ew = d;
		if (a == 8'h02 && (d & 8'h91) == 8'h91) el = d;
		repeat (2) @(posedge mclk);
		#2 check_regs();
	endtask
	task id_read(input logic [7:0] c);
		idq = {};
		fork
			link_u.frame(5);
			begin
				repeat (6) @(posedge mclk);
				#2 cmd = c;
				cv = 1;
				@(posedge mclk) #2 cv = 0;
			end
		join
		chk("idlen", (c inside {8'h9f, 8'h9e}) ? 6 : 0, idq.size());
		if (c inside {8'h9f, 8'h9e})
		begin
			chk("id", {8'h3c, 8'h4d, 8'h6e, 8'h02}, {idq[0], idq[1], idq[2], idq[3]});
			chk("idrev", 8'h00, idq[4]);
			chk("idcfg", (smode == 8'he7) ? 8'h04 : 8'h00, idq[5]);
		end
		$display("id done");
	endtask
	initial
	begin
		do_reset(1);
		foreach (vec[i]) wr8(vec[i][15:8], vec[i][7:0]);
		repeat (20) wr8(8'($random(seed)) & 8'h07, 8'($random(seed)));
		$display("register writes done");
		do_reset(0);
		id_read(8'h9f);
		wr8(8'h00, 8'he7);
		id_read(8'h9e);
		id_read(8'($random(seed)) & 8'h7f);
		for (int k = 0; k < 4; k++)
		begin
			wr8(8'h06, 8'hfc + 8'(k));
			bs = $random(seed);
			load = 1;
			@(posedge mclk) #2 load = 0;
			link_u.frame(20);
			chk("burst", (k == 3) ? bs + 20 : (bs & ~((32'd16 << k) - 1))
				| ((bs + 20) & ((32'd16 << k) - 1)), ba);
		end
		$display("burst done");
		do_reset(1);
		finish_test();
	end
	task finish_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
endmodule // flash_volatile_config_wrap_id_tb
